// ### core/hdd_datapath.sv
// Hard-disk sector data path: local bus port, serial_parallel_converter,
// ID comparator, check code, gap counters and drive sequencing.
// Assumes the drive link pins are asynchronous to mclk.
`timescale 1ns/10ps
module hdd_datapath #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [15:0] lb_addr,
  input  wire logic [15:0] lb_wdata,
  input  wire logic        lb_wr,
  input  wire logic        lb_rd,
  output logic      [15:0] lb_rdata,
  output logic             lb_ready,
  input  wire logic        disk_clk,
  input  wire logic        rd_data_p,
  input  wire logic        rd_data_n,
  input  wire logic        sector_mark,
  input  wire logic        drive_ready,
  input  wire logic        drive_fault,
  output logic             wr_data_p,
  output logic             wr_data_n,
  output logic             wr_gate,
  output logic             rd_gate,
  output logic      [1:0]  drive_sel,
  output logic             head_sel
);
  // Two-stage synchronisers for every link input
  logic [5:0] sync1, sync2;
  logic       clk_d, mark_d;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1  <= '0;
      sync2  <= '0;
      clk_d  <= 1'b0;
      mark_d <= 1'b0;
    end
    else
    begin
      sync1  <= {drive_ready, disk_clk, rd_data_p, rd_data_n, sector_mark,
                 drive_fault};
      sync2  <= sync1;
      clk_d  <= sync2[4];
      mark_d <= sync2[1];
    end
  end
  logic bit_tick, mark_edge, rx_bit, rx_valid, fault_s, ready_s;
  assign bit_tick  = sync2[4] && !clk_d;
  assign mark_edge = sync2[1] && !mark_d;
  assign rx_bit    = sync2[3];
  assign rx_valid  = sync2[3] ^ sync2[2];
  assign fault_s   = sync2[0];
  assign ready_s   = sync2[5];

  // Write holding buffer; back-pressure holds lb_ready low when full
  logic [15:0] wb_data;
  logic        wb_valid, wb_in_ready, wb_pop, wb_push;
  hdd_word_fifo #(.WIDTH(hdd_pkg::WORD_W), .DEPTH(BUF_DEPTH)) u_wbuf (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_data   (lb_wdata),
    .in_valid  (wb_push),
    .in_ready  (wb_in_ready),
    .out_data  (wb_data),
    .out_valid (wb_valid),
    .out_ready (wb_pop)
  );

  hdd_pkg::hdd_state_e state, next_state;
  logic [31:0] target, next_target, shreg, next_shreg, ecc, next_ecc;
  logic [15:0] cmd, next_cmd, rbuf, next_rbuf, wcnt, next_wcnt;
  logic [15:0] gap1, gap2, gap3, next_gap1, next_gap2, next_gap3;
  logic [15:0] gap_cnt, next_gap_cnt, words, next_words;
  logic [15:0] next_rdata;
  logic [5:0]  bcnt, next_bcnt;
  logic        rfull, next_rfull, ack, next_ack, id_hit, next_id_hit;
  logic        done, next_done, ecc_err, next_ecc_err, ovr, next_ovr;
  logic        udr, next_udr, flt, next_flt, wbit, next_wbit;
  logic        next_wr_gate, next_rd_gate;
  logic        writing, fmt, tx, din, fb, gap_end;
  logic        sel_wb, sel_rb, take;
  logic [31:0] ecc_upd;

  assign writing = cmd[hdd_pkg::C_WRITE];
  assign fmt     = cmd[hdd_pkg::C_FORMAT];
  assign tx      = shreg[31];
  assign sel_wb  = (lb_addr == hdd_pkg::A_WBUF);
  assign sel_rb  = (lb_addr == hdd_pkg::A_RBUF);
  // Ready once the buffer can take the word or read data is latched
  assign take    = (lb_wr || lb_rd) && !ack
                   && !(lb_wr && sel_wb && !wb_in_ready);
  assign wb_push = take && lb_wr && sel_wb;
  assign gap_end = (gap_cnt <= 16'h0001);
  // Check code shift, MSB first; message then code leaves zero
  assign din     = (state == hdd_pkg::ST_ID && !fmt) ||
                   ((state == hdd_pkg::ST_DATA ||
                     state == hdd_pkg::ST_ECC) && !writing) ? rx_bit : tx;
  assign fb      = ecc[31] ^ din;
  assign ecc_upd = {ecc[30:0], 1'b0} ^ (fb ? hdd_pkg::ECC_POLY : '0);

  always_comb
  begin
    next_state   = state;
    next_target  = target;
    next_shreg   = shreg;
    next_ecc     = ecc;
    next_cmd     = cmd;
    next_rbuf    = rbuf;
    next_rfull   = rfull;
    next_wcnt    = wcnt;
    next_gap1    = gap1;
    next_gap2    = gap2;
    next_gap3    = gap3;
    next_gap_cnt = gap_cnt;
    next_words   = words;
    next_bcnt    = bcnt;
    next_id_hit  = id_hit;
    next_done    = done;
    next_ecc_err = ecc_err;
    next_ovr     = ovr;
    next_udr     = udr;
    next_flt     = flt;
    next_wbit    = wbit;
    next_ack     = take;
    next_rdata   = lb_rdata;
    wb_pop       = 1'b0;
    // Local bus register port
    if (take && lb_wr)
    begin
      case (lb_addr)
        hdd_pkg::A_ID_LO: next_target[15:0]  = lb_wdata;
        hdd_pkg::A_ID_HI: next_target[31:16] = lb_wdata;
        hdd_pkg::A_GAP1:  next_gap1 = lb_wdata;
        hdd_pkg::A_GAP2:  next_gap2 = lb_wdata;
        hdd_pkg::A_GAP3:  next_gap3 = lb_wdata;
        hdd_pkg::A_WCNT:  next_wcnt = lb_wdata;
        hdd_pkg::A_CMD:   next_cmd  = lb_wdata;
        default: ;
      endcase
    end
    if (take && lb_rd)
    begin
      case (lb_addr)
        hdd_pkg::A_ID_LO: next_rdata = target[15:0];
        hdd_pkg::A_ID_HI: next_rdata = target[31:16];
        hdd_pkg::A_GAP1:  next_rdata = gap1;
        hdd_pkg::A_GAP2:  next_rdata = gap2;
        hdd_pkg::A_GAP3:  next_rdata = gap3;
        hdd_pkg::A_WCNT:  next_rdata = wcnt;
        hdd_pkg::A_CMD:   next_rdata = cmd;
        hdd_pkg::A_RBUF:  next_rdata = rbuf;
        hdd_pkg::A_STAT:  next_rdata = {6'h00, state != hdd_pkg::ST_IDLE,
                                        ready_s, id_hit, done, flt, udr,
                                        ovr, ecc_err, rfull, wb_in_ready};
        default:          next_rdata = 16'h0000;
      endcase
      if (sel_rb)
        next_rfull = 1'b0;
    end
    case (state)
      hdd_pkg::ST_IDLE:
      begin
        if (take && lb_wr && lb_addr == hdd_pkg::A_CMD
            && lb_wdata[hdd_pkg::C_START] && ready_s)
        begin
          next_state   = hdd_pkg::ST_SECT;
          next_done    = 1'b0;
          next_ecc_err = 1'b0;
          next_ovr     = 1'b0;
          next_udr     = 1'b0;
          next_flt     = 1'b0;
          next_id_hit  = 1'b0;
        end
      end
      hdd_pkg::ST_SECT:
      begin
        if (mark_edge)
        begin
          next_state   = hdd_pkg::ST_GAP1;
          next_gap_cnt = gap1;
        end
      end
      hdd_pkg::ST_GAP1, hdd_pkg::ST_GAP2, hdd_pkg::ST_GAP3:
      begin
        if (bit_tick)
        begin
          next_gap_cnt = gap_cnt - 16'h0001;
          next_ecc     = hdd_pkg::ECC_SEED;
          next_bcnt    = '0;
          if (gap_end && state == hdd_pkg::ST_GAP1)
          begin
            next_state = hdd_pkg::ST_ID;
            next_shreg = target;
          end
          else if (gap_end && state == hdd_pkg::ST_GAP2)
          begin
            next_state = hdd_pkg::ST_DATA;
            next_words = wcnt;
            if (writing && !wb_valid)
            begin
              next_udr   = 1'b1;
              next_state = hdd_pkg::ST_IDLE;
            end
            else if (writing)
            begin
              next_shreg = {wb_data, 16'h0000};
              wb_pop     = 1'b1;
            end
          end
          else if (gap_end)
          begin
            next_state = hdd_pkg::ST_IDLE;
            next_done  = 1'b1;
          end
        end
      end
      hdd_pkg::ST_ID:
      begin
        if (bit_tick)
        begin
          next_bcnt = bcnt + 6'h01;
          if (bcnt <= hdd_pkg::ID_LAST || !fmt)
            next_ecc = ecc_upd;
          if (fmt)
            next_shreg = {shreg[30:0], 1'b0};
          else
            next_shreg = {shreg[30:0], rx_bit};
          if (bcnt == hdd_pkg::ID_LAST && fmt)
            next_shreg = ecc_upd;
          if (bcnt == hdd_pkg::ID_LAST && !fmt)
            next_id_hit = ({shreg[30:0], rx_bit} == target);
          if (bcnt == hdd_pkg::FLD_LAST)
          begin
            next_gap_cnt = gap2;
            if (fmt || (id_hit && ecc_upd == '0))
              next_state = hdd_pkg::ST_GAP2;
            else
            begin
              next_state = hdd_pkg::ST_SECT;
              if (id_hit)
                next_ecc_err = 1'b1;
            end
          end
        end
      end
      hdd_pkg::ST_DATA:
      begin
        if (bit_tick)
        begin
          next_bcnt = bcnt + 6'h01;
          next_ecc  = ecc_upd;
          if (writing)
            next_shreg = {shreg[30:0], 1'b0};
          else
            next_shreg = {shreg[30:0], rx_bit};
          if (bcnt == hdd_pkg::WORD_LAST)
          begin
            next_bcnt  = '0;
            next_words = words - 16'h0001;
            if (!writing)
            begin
              next_rbuf  = {shreg[14:0], rx_bit};
              next_rfull = 1'b1;
              if (rfull && !(take && lb_rd && sel_rb))
                next_ovr = 1'b1;
            end
            if (words <= 16'h0001)
            begin
              next_state = hdd_pkg::ST_ECC;
              if (writing)
                next_shreg = ecc_upd;
            end
            else if (writing && !wb_valid)
            begin
              next_udr   = 1'b1;
              next_state = hdd_pkg::ST_IDLE;
            end
            else if (writing)
            begin
              next_shreg = {wb_data, 16'h0000};
              wb_pop     = 1'b1;
            end
          end
        end
      end
      hdd_pkg::ST_ECC:
      begin
        if (bit_tick)
        begin
          next_bcnt  = bcnt + 6'h01;
          next_shreg = {shreg[30:0], 1'b0};
          if (!writing)
            next_ecc = ecc_upd;
          if (bcnt == hdd_pkg::ECC_LAST)
          begin
            next_state   = hdd_pkg::ST_GAP3;
            next_gap_cnt = gap3;
            if (!writing && ecc_upd != '0)
              next_ecc_err = 1'b1;
          end
        end
      end
      default: next_state = hdd_pkg::ST_IDLE;
    endcase
    // Drive status aborts any transfer in flight
    if (state != hdd_pkg::ST_IDLE && (fault_s || !ready_s))
    begin
      next_state = hdd_pkg::ST_IDLE;
      next_flt   = 1'b1;
    end
    if (bit_tick)
      next_wbit = tx;
    next_wr_gate = writing && (next_state == hdd_pkg::ST_DATA ||
                   next_state == hdd_pkg::ST_ECC ||
                   (fmt && next_state == hdd_pkg::ST_ID));
    next_rd_gate = !writing && next_state != hdd_pkg::ST_IDLE
                   && !(fmt && next_state == hdd_pkg::ST_ID);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= hdd_pkg::ST_IDLE;
      target   <= '0;
      shreg    <= '0;
      ecc      <= hdd_pkg::ECC_SEED;
      cmd      <= '0;
      rbuf     <= '0;
      rfull    <= 1'b0;
      wcnt     <= hdd_pkg::WCNT_RST;
      gap1     <= hdd_pkg::GAP_RST;
      gap2     <= hdd_pkg::GAP_RST;
      gap3     <= hdd_pkg::GAP_RST;
      gap_cnt  <= '0;
      words    <= '0;
      bcnt     <= '0;
      id_hit   <= 1'b0;
      done     <= 1'b0;
      ecc_err  <= 1'b0;
      ovr      <= 1'b0;
      udr      <= 1'b0;
      flt      <= 1'b0;
      wbit     <= 1'b0;
      ack      <= 1'b0;
      lb_rdata <= '0;
      wr_gate  <= 1'b0;
      rd_gate  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      target   <= next_target;
      shreg    <= next_shreg;
      ecc      <= next_ecc;
      cmd      <= next_cmd;
      rbuf     <= next_rbuf;
      rfull    <= next_rfull;
      wcnt     <= next_wcnt;
      gap1     <= next_gap1;
      gap2     <= next_gap2;
      gap3     <= next_gap3;
      gap_cnt  <= next_gap_cnt;
      words    <= next_words;
      bcnt     <= next_bcnt;
      id_hit   <= next_id_hit;
      done     <= next_done;
      ecc_err  <= next_ecc_err;
      ovr      <= next_ovr;
      udr      <= next_udr;
      flt      <= next_flt;
      wbit     <= next_wbit;
      ack      <= next_ack;
      lb_rdata <= next_rdata;
      wr_gate  <= next_wr_gate;
      rd_gate  <= next_rd_gate;
    end
  end

  assign lb_ready  = ack;
  assign wr_data_p = wbit;
  assign wr_data_n = !wbit;
  assign drive_sel = cmd[hdd_pkg::C_SEL_HI:hdd_pkg::C_SEL_LO];
  assign head_sel  = cmd[hdd_pkg::C_HEAD];
endmodule : hdd_datapath

// ### core/hdd_pkg.sv
// Constants shared by the disk sector data path and its word buffer.
// Assumes a 16-bit local bus from the transfer processor and one drive link.
package hdd_pkg;
  localparam int          WORD_W     = 16;
  localparam int          ID_W       = 32;
  localparam int          ECC_W      = 32;
  localparam int          MCLK_NS    = 25;
  // Fire-type code, MSB first, register cleared before each field
  localparam logic [31:0] ECC_POLY   = 32'h00a00805;
  localparam logic [31:0] ECC_SEED   = 32'h00000000;
  localparam logic [15:0] A_ID_LO    = 16'h8020;
  localparam logic [15:0] A_ID_HI    = 16'h8022;
  localparam logic [15:0] A_CMD      = 16'h8024;
  localparam logic [15:0] A_STAT     = 16'h8026;
  localparam logic [15:0] A_WBUF     = 16'h8028;
  localparam logic [15:0] A_RBUF     = 16'h802a;
  localparam logic [15:0] A_GAP1     = 16'h8030;
  localparam logic [15:0] A_GAP2     = 16'h8032;
  localparam logic [15:0] A_GAP3     = 16'h8034;
  localparam logic [15:0] A_WCNT     = 16'h8036;
  localparam int          C_START    = 0;
  localparam int          C_WRITE    = 1;
  localparam int          C_FORMAT   = 2;
  localparam int          C_SEL_LO   = 4;
  localparam int          C_SEL_HI   = 5;
  localparam int          C_HEAD     = 8;
  localparam logic [15:0] GAP_RST    = 16'h0010;
  localparam logic [15:0] WCNT_RST   = 16'h0100;
  localparam logic [5:0]  ID_LAST    = 6'h1f;
  localparam logic [5:0]  FLD_LAST   = 6'h3f;
  localparam logic [5:0]  WORD_LAST  = 6'h0f;
  localparam logic [5:0]  ECC_LAST   = 6'h1f;
  typedef enum logic [2:0] {ST_IDLE, ST_SECT, ST_GAP1, ST_ID, ST_GAP2,
                            ST_DATA, ST_ECC, ST_GAP3} hdd_state_e;
endpackage : hdd_pkg

// ### core/hdd_word_fifo.sv
// Small word buffer with valid/ready on both sides.
// Assumes one clock; storage is flip-flops indexed by pointers.
`timescale 1ns/10ps
module hdd_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_param
    $error("hdd_word_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0]      count, next_count;
  logic             push, pop;

  assign in_ready  = (count != DEPTH[PW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = wr_ptr + 1'b1;
    end
    if (pop)
      next_rd_ptr = rd_ptr + 1'b1;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule : hdd_word_fifo

// ### verif/hdd_datapath_monitor.sv
// Port checks for the sector data path.
// Assumes a bind onto hdd_datapath, one mclk domain.
`timescale 1ns/10ps
module hdd_datapath_monitor #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [15:0] lb_addr,
  input wire logic        lb_wr,
  input wire logic        lb_rd,
  input wire logic [15:0] lb_rdata,
  input wire logic        lb_ready,
  input wire logic        disk_clk,
  input wire logic        drive_ready,
  input wire logic        drive_fault,
  input wire logic        wr_data_p,
  input wire logic        wr_data_n,
  input wire logic        wr_gate,
  input wire logic        rd_gate,
  input wire logic [1:0]  drive_sel,
  input wire logic        head_sel
);
  logic       dclk_q;
  logic       next_dclk_q;
  logic [3:0] tick_age;
  logic [3:0] next_tick_age;
  logic       cmd_wr;

  assign cmd_wr = lb_wr && (lb_addr == hdd_pkg::A_CMD);

  // Cycles since the raw link clock last rose, saturating
  always_comb
  begin
    next_dclk_q   = disk_clk;
    next_tick_age = (disk_clk && !dclk_q) ? 4'h0 :
                    tick_age + {3'h0, tick_age != 4'hf};
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dclk_q   <= 1'h0;
      tick_age <= 4'hf;
    end
    else
    begin
      dclk_q   <= next_dclk_q;
      tick_age <= next_tick_age;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_ready_pulse: assert property (lb_ready |=> !lb_ready)
    else $error("ready held past one cycle");
  a_ready_cause: assert property ($rose(lb_ready) |-> $past(lb_wr || lb_rd))
    else $error("ready without a request");
  a_ready_prompt: assert property ((lb_wr || lb_rd) && !lb_ready &&
    lb_addr != hdd_pkg::A_WBUF |=> lb_ready)
    else $error("register access not answered next cycle");
  a_rdata_hold: assert property ($changed(lb_rdata) |-> lb_ready && $past(lb_rd))
    else $error("read data moved outside a read answer");
  a_sel_by_cmd: assert property ($changed({head_sel, drive_sel}) |->
    $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("drive select changed without a command write");
  a_nrz_pair: assert property (wr_data_n == !wr_data_p)
    else $error("write pair not complementary");
  a_bit_on_tick: assert property (wr_gate && $past(wr_gate) &&
    $changed(wr_data_p) |-> tick_age <= 4'h7)
    else $error("write bit changed away from a link tick");
  a_gate_on_tick: assert property ($rose(wr_gate) |-> tick_age <= 4'h7)
    else $error("write gate opened away from a link tick");
  a_fault_abort: assert property (drive_fault |->
    ##[1:8] !(wr_gate || rd_gate))
    else $error("gates still open after a fault");
  a_unready_abort: assert property (!drive_ready |->
    ##[1:8] !(wr_gate || rd_gate))
    else $error("gates open while drive not ready");

  c_write_gate: cover property ($rose(wr_gate));
  c_read_gate: cover property ($rose(rd_gate));
  c_fault_busy: cover property (drive_fault && rd_gate);
  c_read_ack: cover property (lb_ready && lb_rd);
endmodule : hdd_datapath_monitor

// ### verif/hdd_drive_model.sv
// Drive model: sector frames on the read pair, capture of written bits.
// Assumes the bench arms the controller before calling send_sector.
`timescale 1ns/10ps
module hdd_drive_model (
  output logic      disk_clk,
  output logic      rd_data_p,
  output logic      rd_data_n,
  output logic      sector_mark,
  output logic      drive_ready,
  output logic      drive_fault,
  input  wire logic wr_data_p,
  input  wire logic wr_gate
);
  logic bits[$];
  logic cap[$];
  logic gate_q;

  // Link clock stands still outside frames
  initial
  begin
    disk_clk    = 1'h0;
    rd_data_p   = 1'h0;
    rd_data_n   = 1'h1;
    sector_mark = 1'h0;
    drive_ready = 1'h1;
    drive_fault = 1'h0;
    gate_q      = 1'h0;
  end

  function automatic logic [31:0] crc(input logic [31:0] c,
                                      input logic [31:0] v, input int n);
    logic fb;
    for (int i = n - 1; i >= 0; i--)
    begin
      fb = c[31] ^ v[i];
      c  = {c[30:0], 1'h0} ^ (fb ? hdd_pkg::ECC_POLY : 32'h0);
    end
    return c;
  endfunction : crc

  task automatic push(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      bits.push_back(v[i]);
  endtask : push

  task automatic send_sector(input logic [31:0] id, input logic [15:0] w0,
                             input logic [15:0] w1, input logic bad,
                             input int gap);
    bits.delete();
    push(32'h55555555, gap);
    push(id, 32);
    push(crc(hdd_pkg::ECC_SEED, id, 32), 32);
    push(32'h55555555, gap);
    push({w0, w1}, 32);
    push(crc(hdd_pkg::ECC_SEED, {w0, w1}, 32) ^ {31'h0, bad}, 32);
    push(32'h55555555, gap + 2);
    sector_mark = 1'h1;
    #400 sector_mark = 1'h0;
    #400;
    foreach (bits[i])
    begin
      rd_data_p = bits[i];
      rd_data_n = !bits[i];
      #100 disk_clk = 1'h1;
      #100 disk_clk = 1'h0;
    end
    // Idle line shows the inverse, never a stale bit
    rd_data_p = !rd_data_p;
    rd_data_n = !rd_data_n;
  endtask : send_sector

  // One sample past the gate so the last code bit is kept
  always @(posedge disk_clk)
  begin
    if (wr_gate || gate_q)
      cap.push_back(wr_data_p);
    gate_q = wr_gate;
  end
endmodule : hdd_drive_model

// ### verif/tb_hdd_datapath.sv
// Bench for hdd_datapath: local bus driver, read scoreboard, drive model.
// Assumes hdd_pkg, design files, drive model and monitor compile first.
`timescale 1ns/10ps
module tb_hdd_datapath;
  logic        mclk;
  logic        reset_n;
  logic [15:0] lb_addr;
  logic [15:0] lb_wdata;
  logic        lb_wr;
  logic        lb_rd;
  logic [15:0] lb_rdata;
  logic        lb_ready;
  logic        disk_clk;
  logic        rd_data_p;
  logic        rd_data_n;
  logic        sector_mark;
  logic        drive_ready;
  logic        drive_fault;
  logic        wr_data_p;
  logic        wr_data_n;
  logic        wr_gate;
  logic        rd_gate;
  logic [1:0]  drive_sel;
  logic        head_sel;
  integer      seed;
  int          bad_count;
  int          n_checks;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] q;
  logic [31:0] tid;
  logic [15:0] w0;
  logic [15:0] w1;

  hdd_datapath #(.BUF_DEPTH(2)) u_hdd_datapath (
    .mclk(mclk), .reset_n(reset_n), .lb_addr(lb_addr),
    .lb_wdata(lb_wdata), .lb_wr(lb_wr), .lb_rd(lb_rd),
    .lb_rdata(lb_rdata), .lb_ready(lb_ready), .disk_clk(disk_clk),
    .rd_data_p(rd_data_p), .rd_data_n(rd_data_n),
    .sector_mark(sector_mark), .drive_ready(drive_ready),
    .drive_fault(drive_fault), .wr_data_p(wr_data_p),
    .wr_data_n(wr_data_n), .wr_gate(wr_gate), .rd_gate(rd_gate),
    .drive_sel(drive_sel), .head_sel(head_sel));

  hdd_drive_model u_hdd_drive_model (
    .disk_clk(disk_clk), .rd_data_p(rd_data_p), .rd_data_n(rd_data_n),
    .sector_mark(sector_mark), .drive_ready(drive_ready),
    .drive_fault(drive_fault), .wr_data_p(wr_data_p), .wr_gate(wr_gate));

  always #12.5 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Strobe held until ready is sampled, dropped just after
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    int i;
    @(posedge mclk);
    #2;
    lb_addr  = a;
    lb_wdata = d;
    lb_wr    = w;
    lb_rd    = !w;
    for (i = 0; i < 2000; i++)
    begin
      @(posedge mclk);
      if (lb_ready === 1'h1) break;
    end
    q = lb_rdata;
    #2;
    lb_wr = 1'h0;
    lb_rd = 1'h0;
    if (i == 2000)
    begin
      bad_count++;
      end_sim();
    end
  endtask : bus

  task automatic rd(input logic [15:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'h0, a, 16'h0);
  endtask : rd

  task automatic poll(input int b, input logic v);
    int i;
    for (i = 0; i < 500; i++)
    begin
      bus(1'h0, hdd_pkg::A_STAT, 16'h0);
      if (q[b] === v) break;
    end
    if (i == 500)
    begin
      bad_count++;
      end_sim();
    end
  endtask : poll

  function automatic logic found(input logic [63:0] p);
    logic hit;
    logic ok;
    hit = 1'h0;
    for (int s = 0; s + 64 <= u_hdd_drive_model.cap.size(); s++)
    begin
      ok = 1'h1;
      for (int j = 0; j < 64; j++)
        if (u_hdd_drive_model.cap[s + j] !== p[63 - j]) ok = 1'h0;
      hit |= ok;
    end
    return hit;
  endfunction : found

  // Scoreboard: oldest read note against each read answer while notes are queued
  always @(posedge mclk)
  begin
    if (lb_ready === 1'h1 && lb_rd === 1'h1 && exp_q.size() > 0)
      check(lb_rdata & msk_q.pop_front(), exp_q.pop_front());
  end

  initial
  begin
    mclk = 1'h0;
    reset_n = 1'h0;
    lb_addr = 16'h0;
    lb_wdata = 16'h0;
    lb_wr = 1'h0;
    lb_rd = 1'h0;
    seed = 53724;
    bad_count = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    #2 reset_n = 1'h1;
    rd(hdd_pkg::A_GAP1, hdd_pkg::GAP_RST, 16'hffff);
    rd(hdd_pkg::A_WCNT, hdd_pkg::WCNT_RST, 16'hffff);
    rd(hdd_pkg::A_STAT, 16'h0101, 16'h0301);
    rd(hdd_pkg::A_WBUF, 16'h0, 16'hffff);
    rd(16'h9000, 16'h0, 16'hffff);
    bus(1'h1, 16'h9000, 16'hffff);
    bus(1'h1, hdd_pkg::A_GAP1, 16'h0004);
    bus(1'h1, hdd_pkg::A_GAP2, 16'h0004);
    bus(1'h1, hdd_pkg::A_GAP3, 16'h0004);
    bus(1'h1, hdd_pkg::A_WCNT, 16'h0002);
    rd(hdd_pkg::A_GAP3, 16'h0004, 16'hffff);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'h1, hdd_pkg::A_CMD, {7'h0, k[0], 2'h0, k[1:0], 4'h0});
      #50;
      check({29'h0, head_sel, drive_sel}, {29'h0, k[0], k[1:0]});
    end
    $display("test map done");
    tid = $random(seed);
    {w0, w1} = $random(seed);
    bus(1'h1, hdd_pkg::A_ID_LO, tid[15:0]);
    bus(1'h1, hdd_pkg::A_ID_HI, tid[31:16]);
    bus(1'h1, hdd_pkg::A_WBUF, w0);
    bus(1'h1, hdd_pkg::A_WBUF, w1);
    rd(hdd_pkg::A_STAT, 16'h0, 16'h0001);
    bus(1'h1, hdd_pkg::A_CMD, 16'h0003);
    u_hdd_drive_model.cap.delete();
    u_hdd_drive_model.send_sector(~tid, w1, w0, 1'h0, 4);
    check(u_hdd_drive_model.cap.size(), 0);
    u_hdd_drive_model.send_sector(tid, w0, w1, 1'h0, 4);
    check({31'h0, found({w0, w1, u_hdd_drive_model.crc(hdd_pkg::ECC_SEED,
          {w0, w1}, 32)})}, 32'h1);
    poll(6, 1'h1);
    rd(hdd_pkg::A_STAT, 16'h00c1, 16'h00dd);
    $display("test write done");
    for (int b = 0; b < 2; b++)
    begin
      {w0, w1} = $random(seed);
      bus(1'h1, hdd_pkg::A_CMD, 16'h0001);
      // Single read holding word: drain each one before the next lands
      fork
        u_hdd_drive_model.send_sector(tid, w0, w1, b[0], 4);
        begin
          poll(1, 1'h1);
          rd(hdd_pkg::A_RBUF, w0, 16'hffff);
          poll(1, 1'h1);
          rd(hdd_pkg::A_RBUF, w1, 16'hffff);
        end
      join
      #250;
      rd(hdd_pkg::A_STAT, {13'h0, b[0], 2'h0}, 16'h000c);
      $display("test read %0d done", b);
    end
    #2 u_hdd_drive_model.drive_fault = 1'h1;
    #500 u_hdd_drive_model.drive_fault = 1'h0;
    poll(9, 1'h0);
    bus(1'h1, hdd_pkg::A_CMD, 16'h0001);
    #500;
    check(rd_gate, 1'h1);
    u_hdd_drive_model.drive_fault = 1'h1;
    #500;
    check(rd_gate, 1'h0);
    rd(hdd_pkg::A_STAT, 16'h0020, 16'h0220);
    u_hdd_drive_model.drive_fault = 1'h0;
    u_hdd_drive_model.drive_ready = 1'h0;
    #100;
    rd(hdd_pkg::A_STAT, 16'h0, 16'h0100);
    bus(1'h1, hdd_pkg::A_CMD, 16'h0001);
    #250;
    rd(hdd_pkg::A_STAT, 16'h0, 16'h0200);
    u_hdd_drive_model.drive_ready = 1'h1;
    $display("test fault done");
    end_sim();
  end
endmodule : tb_hdd_datapath

bind hdd_datapath hdd_datapath_monitor #(.BUF_DEPTH(BUF_DEPTH))
  u_hdd_datapath_monitor (
  .mclk(mclk), .reset_n(reset_n), .lb_addr(lb_addr), .lb_wr(lb_wr),
  .lb_rd(lb_rd), .lb_rdata(lb_rdata), .lb_ready(lb_ready),
  .disk_clk(disk_clk), .drive_ready(drive_ready),
  .drive_fault(drive_fault), .wr_data_p(wr_data_p),
  .wr_data_n(wr_data_n), .wr_gate(wr_gate), .rd_gate(rd_gate),
  .drive_sel(drive_sel), .head_sel(head_sel));
